//--- hdl/hzs_pkg.sv
package hzs_pkg;

  localparam int NCH = 8;
  localparam int CLK_HZ = 10_000_000;

  // Command image bit positions, zero based; printed bit n sits at index n-1.
  localparam int CMD_W = 24;
  localparam int CMD_AUTO_BASE = 0;
  localparam int CMD_OEN_BASE = 1;
  localparam int CMD_METHOD = 18;
  localparam int CMD_TUNE_GO = 19;
  localparam int CMD_CAL_DIS = 21;
  localparam int CMD_TUNE_CANCEL = 23;

  // Status image: seven bits per channel starting at index 0, module bits above.
  localparam int STAT_W = 64;
  localparam int CH_STRIDE = 7;
  localparam int ST_UA = 0;
  localparam int ST_LA = 1;
  localparam int ST_UD = 2;
  localparam int ST_LD = 3;
  localparam int ST_TCE = 4;
  localparam int ST_SHORT = 5;
  localparam int ST_ZONE = 6;
  localparam int ST_REF_FAULT = 56;
  localparam int ST_TUNING = 58;
  localparam int ST_CAL = 59;
  localparam int ST_HEARTBEAT = 60;
  localparam int ST_EXT_FAIL = 62;
  localparam int ST_MOD_ERR = 63;

  // Thermocouple condition codes {zone, tc}.
  localparam logic [1:0] TC_OK = 2'h0;
  localparam logic [1:0] TC_OPEN = 2'h1;
  localparam logic [1:0] TC_REVERSE = 2'h3;

  // Error code word layout.
  localparam int ERR_EPROM = 0;
  localparam int ERR_RAM = 1;
  localparam int ERR_SUPPLY = 7;

  localparam logic [15:0] CJ_MIN = 16'h0000;
  localparam logic [15:0] CJ_MAX = 16'h0258;

  localparam int CAL_MS = 3000;
  localparam int CAL_CYC = CAL_MS * (CLK_HZ / 1000);
  localparam int PSET_MS = 1000;
  localparam int PSET_CYC = PSET_MS * (CLK_HZ / 1000);
  localparam int HB_CYC = CLK_HZ / 2;
  localparam int NPARAM = 6;

  typedef enum logic [1:0] {
    HZS_IDLE   = 2'b00,
    HZS_RUN    = 2'b01,
    HZS_REPORT = 2'b10
  } hzs_tune_t;

endpackage : hzs_pkg

//--- hdl/hzs_ch_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hzs_ch_if;
  logic signed [15:0] temp;
  logic signed [15:0] ua;
  logic signed [15:0] la;
  logic signed [15:0] ud;
  logic signed [15:0] ld;
  logic [1:0]         tc_code;
  logic               cj_bad;
  logic               ext_fail;
  logic               short;
  logic [6:0]         flags;
  modport src (output temp, ua, la, ud, ld, tc_code, cj_bad, ext_fail, short, input flags);
  modport chk (input temp, ua, la, ud, ld, tc_code, cj_bad, ext_fail, short, output flags);
endinterface : hzs_ch_if
`default_nettype wire

//--- hdl/hzs_ch_flags.sv
`timescale 1ns/10ps
`default_nettype none
module hzs_ch_flags
  import hzs_pkg::*;
(
  hzs_ch_if.chk ch
);
  logic ua;
  logic la;
  logic ud;
  logic ld;
  logic tcf;
  logic m;

  always_comb begin
    m   = ch.ext_fail;
    tcf = (ch.tc_code == TC_OPEN) || (ch.tc_code == TC_REVERSE);
    ua  = ch.temp > ch.ua;
    la  = ch.temp < ch.la;
    ud  = ch.temp > ch.ud;
    ld  = ch.temp < ch.ld;
    ch.flags = '0;
    ch.flags[ST_SHORT] = ch.short && !m;
    if (!m && !ch.cj_bad) begin
      ch.flags[ST_TCE]  = ch.tc_code[0];
      ch.flags[ST_ZONE] = ch.tc_code[1];
      if (!tcf) begin
        ch.flags[ST_UA] = ua;
        ch.flags[ST_UD] = ud && !ua;
        ch.flags[ST_LA] = la && !ua && !ud;
        ch.flags[ST_LD] = ld && !ua && !ud && !la;
      end
    end
  end
endmodule : hzs_ch_flags
`default_nettype wire

//--- hdl/hzs_io.sv
`timescale 1ns/10ps
`default_nettype none
module hzs_io
  import hzs_pkg::*;
#(
  parameter int CAL_CYCLES  = CAL_CYC,
  parameter int PSET_CYCLES = PSET_CYC,
  parameter int HB_CYCLES   = HB_CYC
) (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Host scan transfer.
  input  wire logic                      scan_strobe,
  input  wire logic [CMD_W-1:0]          discrete_command_image,
  output logic      [STAT_W-1:0]         status_flag_image,
  // Measurement and limits per channel.
  input  wire logic [NCH-1:0][15:0]      meas_temp,
  input  wire logic [NCH-1:0][15:0]      upper_alarm,
  input  wire logic [NCH-1:0][15:0]      lower_alarm,
  input  wire logic [NCH-1:0][15:0]      upper_dev,
  input  wire logic [NCH-1:0][15:0]      lower_dev,
  input  wire logic [NCH-1:0][15:0]      setpoint,
  input  wire logic [NCH-1:0][1:0]       thermocouple_code,
  input  wire logic [NCH-1:0]            channel_active,
  input  wire logic [NCH-1:0]            driver_short,
  // Module health.
  input  wire logic [15:0]               comp_temp,
  input  wire logic                      cj_sensor_short,
  input  wire logic                      cj_sensor_open,
  input  wire logic                      ext_supply_ok,
  input  wire logic                      cal_request,
  input  wire logic                      eprom_fault,
  input  wire logic                      ram_fault,
  input  wire logic                      int_supply_fault,
  input  wire logic                      param_fault,
  input  wire logic [7:0]                param_fault_id,
  // Tuning engine.
  input  wire logic                      tune_done,
  input  wire logic [NCH-1:0][NPARAM-1:0][15:0] tuned_params,
  output logic                           tune_run,
  output logic                           tune_step_method,
  output logic      [NCH-1:0]            tune_select,
  // Channel control.
  output logic      [NCH-1:0]            closed_loop,
  output logic      [NCH-1:0]            output_enable,
  output logic                           measure_hold,
  // Feedback words 21 to 28.
  output logic      [7:0][15:0]          feedback_words
);
  logic [CMD_W-1:0]   cmd_q;
  logic [STAT_W-1:0]  stat_live;
  logic [NCH-1:0][6:0] chf;
  logic               cj_bad;
  logic               ext_fail;
  logic               ref_fault;
  logic               mod_err;
  logic [15:0]        err_code;
  hzs_tune_t          tst_q;
  logic               go_prev_q;
  logic [NCH-1:0]     sel_q;
  logic [2:0]         rep_ch_q;
  logic [31:0]        rep_cnt_q;
  logic               cal_q;
  logic [31:0]        cal_cnt_q;
  logic               hb_q;
  logic [31:0]        hb_cnt_q;
  logic [NCH-1:0]     eligible;

  assign ext_fail  = !ext_supply_ok;
  assign cj_bad    = ($signed(comp_temp) < $signed(CJ_MIN)) ||
                     ($signed(comp_temp) > $signed(CJ_MAX));
  assign ref_fault = cj_sensor_short || cj_sensor_open;
  assign mod_err   = eprom_fault || ram_fault || int_supply_fault || param_fault;
  assign err_code  = {param_fault ? param_fault_id : 8'h00,
                      int_supply_fault, 5'h00, ram_fault, eprom_fault};

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    hzs_ch_if chi ();
    assign chi.temp     = meas_temp[i];
    assign chi.ua       = upper_alarm[i];
    assign chi.la       = lower_alarm[i];
    assign chi.ud       = upper_dev[i];
    assign chi.ld       = lower_dev[i];
    assign chi.tc_code  = thermocouple_code[i];
    assign chi.cj_bad   = cj_bad;
    assign chi.ext_fail = ext_fail;
    assign chi.short    = driver_short[i];
    assign chf[i]       = chi.flags;
    hzs_ch_flags u_flags (
      .ch (chi)
    );
    assign eligible[i] = channel_active[i] && cmd_q[CMD_OEN_BASE + 2*i] &&
                         !cmd_q[CMD_AUTO_BASE + 2*i] && (setpoint[i] != 16'h0000) &&
                         (thermocouple_code[i] == TC_OK);
    assign closed_loop[i]   = cmd_q[CMD_AUTO_BASE + 2*i];
    assign output_enable[i] = cmd_q[CMD_OEN_BASE + 2*i];
  end

  always_comb begin
    stat_live = '0;
    for (int i = 0; i < NCH; i++) begin
      stat_live[i*CH_STRIDE +: CH_STRIDE] = chf[i];
    end
    stat_live[ST_REF_FAULT] = ref_fault && !ext_fail;
    stat_live[ST_TUNING]    = (tst_q != HZS_IDLE) && !ext_fail;
    stat_live[ST_CAL]       = cal_q && !ext_fail;
    stat_live[ST_HEARTBEAT] = hb_q && !ext_fail;
    stat_live[ST_EXT_FAIL]  = ext_fail;
    stat_live[ST_MOD_ERR]   = mod_err && !ext_fail;
  end

  // Command capture and status publish happen only on the scan strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q             <= '0;
      status_flag_image <= '0;
    end else if (scan_strobe) begin
      cmd_q             <= discrete_command_image;
      status_flag_image <= stat_live;
    end
  end

  // Tuning sequencer: start on a rising start bit, cancel at any time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tst_q     <= HZS_IDLE;
      go_prev_q <= 1'b0;
      sel_q     <= '0;
      rep_ch_q  <= 3'h0;
      rep_cnt_q <= '0;
      tune_step_method <= 1'b0;
    end else begin
      if (scan_strobe) begin
        go_prev_q <= cmd_q[CMD_TUNE_GO];
      end
      if (cmd_q[CMD_TUNE_CANCEL]) begin
        tst_q <= HZS_IDLE;
      end else begin
        unique case (tst_q)
          HZS_IDLE: if (scan_strobe && cmd_q[CMD_TUNE_GO] && !go_prev_q && eligible != '0) begin
            tst_q            <= HZS_RUN;
            sel_q            <= eligible;
            tune_step_method <= cmd_q[CMD_METHOD];
          end
          HZS_RUN: if (tune_done) begin
            tst_q     <= HZS_REPORT;
            rep_ch_q  <= 3'h0;
            rep_cnt_q <= '0;
          end
          HZS_REPORT: begin
            if (rep_cnt_q >= 32'(PSET_CYCLES - 1)) begin
              rep_cnt_q <= '0;
              if (rep_ch_q == 3'(NCH - 1)) begin
                tst_q <= HZS_IDLE;
              end else begin
                rep_ch_q <= rep_ch_q + 3'h1;
              end
            end else begin
              rep_cnt_q <= rep_cnt_q + 32'h0000_0001;
            end
          end
        endcase
      end
    end
  end

  assign tune_run    = (tst_q == HZS_RUN);
  assign tune_select = (tst_q == HZS_RUN) ? sel_q : '0;

  // Feedback words: proposals are only reported, never written to the loops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      feedback_words <= '0;
    end else begin
      feedback_words[0][15:8] <= output_enable;
      if (tst_q == HZS_REPORT && sel_q[rep_ch_q]) begin
        feedback_words[0][7:0] <= 8'({5'h00, rep_ch_q} + 8'h01);
        for (int p = 0; p < NPARAM; p++) begin
          feedback_words[p+1] <= tuned_params[rep_ch_q][p];
        end
      end else begin
        feedback_words[0][7:0] <= 8'h00;
        for (int p = 0; p < NPARAM; p++) begin
          feedback_words[p+1] <= 16'h0000;
        end
      end
      feedback_words[7] <= mod_err ? err_code : 16'h0000;
    end
  end

  // Full calibration cycle, blocked while the disable bit is held.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_q     <= 1'b0;
      cal_cnt_q <= '0;
    end else if (cal_q) begin
      if (cal_cnt_q >= 32'(CAL_CYCLES - 1)) begin
        cal_q <= 1'b0;
      end else begin
        cal_cnt_q <= cal_cnt_q + 32'h0000_0001;
      end
    end else if (cal_request && !cmd_q[CMD_CAL_DIS]) begin
      cal_q     <= 1'b1;
      cal_cnt_q <= '0;
    end
  end

  assign measure_hold = cal_q;

  // Heartbeat toggles while no module error is present.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hb_q     <= 1'b0;
      hb_cnt_q <= '0;
    end else if (mod_err) begin
      hb_q     <= 1'b0;
      hb_cnt_q <= '0;
    end else if (hb_cnt_q >= 32'(HB_CYCLES - 1)) begin
      hb_q     <= ~hb_q;
      hb_cnt_q <= '0;
    end else begin
      hb_cnt_q <= hb_cnt_q + 32'h0000_0001;
    end
  end

endmodule : hzs_io
`default_nettype wire

//--- test/hzs_io_sva.sv
`timescale 1ns/10ps
`default_nettype none
module hzs_io_sva
  import hzs_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC
) (
  // Clock and reset.
  input wire logic                clk,
  input wire logic                rst_n,
  // Watched ports.
  input wire logic                scan_strobe,
  input wire logic [CMD_W-1:0]    discrete_command_image,
  input wire logic [STAT_W-1:0]   status_flag_image,
  input wire logic [NCH-1:0][1:0] thermocouple_code,
  input wire logic [15:0]         comp_temp,
  input wire logic                ext_supply_ok,
  input wire logic                tune_run,
  input wire logic [NCH-1:0]      closed_loop,
  input wire logic [NCH-1:0]      output_enable,
  input wire logic                measure_hold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [NCH-1:0] oen;
  logic           masked;
  logic           cal_dis_q;
  int             hold_q;
  always_comb begin
    for (int i = 0; i < NCH; i++) oen[i] = discrete_command_image[2*i+1];
  end
  assign masked = ext_supply_ok && (comp_temp[15] || comp_temp > CJ_MAX || thermocouple_code[0][0]);
  always_ff @(posedge clk) begin
    if (!rst_n) cal_dis_q <= 1'b0;
    else if (scan_strobe) cal_dis_q <= discrete_command_image[CMD_CAL_DIS];
  end
  // Counts how long the measurement pause has lasted so far.
  always_ff @(posedge clk) begin
    hold_q <= (rst_n && measure_hold) ? hold_q + 1 : 0;
  end
  property p_oen; scan_strobe |=> output_enable == $past(oen); endproperty
  a_oen: assert property (p_oen) else $error("Enable differs from command.");
  property p_hold; !scan_strobe |=> $stable(output_enable) && $stable(closed_loop); endproperty
  a_hold: assert property (p_hold) else $error("Command effect moved between scans.");
  property p_snap; !scan_strobe |=> $stable(status_flag_image); endproperty
  a_snap: assert property (p_snap) else $error("Status changed between scans.");
  property p_ext; !ext_supply_ok ##1 (!ext_supply_ok && scan_strobe) |=> status_flag_image == 64'h4000_0000_0000_0000;
  endproperty
  a_ext: assert property (p_ext) else $error("Supply loss not masking.");
  property p_mask; masked ##1 (masked && scan_strobe) |=> status_flag_image[3:0] == 4'h0; endproperty
  a_mask: assert property (p_mask) else $error("Alarm flags not masked.");
  property p_caldis; cal_dis_q && !measure_hold |=> !measure_hold; endproperty
  a_caldis: assert property (p_caldis) else $error("Calibration while disabled.");
  property p_callen; measure_hold |-> hold_q < CAL_CYCLES; endproperty
  a_callen: assert property (p_callen) else $error("Calibration pause too long.");
  property p_cancel; scan_strobe && discrete_command_image[CMD_TUNE_CANCEL] |-> ##[1:3] !tune_run; endproperty
  a_cancel: assert property (p_cancel) else $error("Tuning not cancelled.");
endmodule : hzs_io_sva
bind hzs_io hzs_io_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.clk, .rst_n, .scan_strobe, .discrete_command_image,
  .status_flag_image, .thermocouple_code, .comp_temp, .ext_supply_ok, .tune_run, .closed_loop, .output_enable,
  .measure_hold);
`default_nettype wire

//--- test/hzs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hzs_host_model
  import hzs_pkg::*;
#(
  parameter int SCAN = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [CMD_W-1:0] cmd_next,
  output var  logic             scan_strobe,
  output var  logic [CMD_W-1:0] discrete_command_image
);
  int   cnt = 0;
  logic run;
  logic [CMD_W-1:0] nxt;
  initial scan_strobe = 1'b0;
  initial discrete_command_image = '0;
  // The whole command image is rewritten every scan and then held until the next one.
  always @(posedge clk) begin
    run = rst_n;
    // Taking the next image at the edge keeps it clear of bench updates made just after it.
    nxt = cmd_next;
    #1;
    cnt = (!run || cnt == SCAN - 1) ? 0 : cnt + 1;
    scan_strobe = run && cnt == 0;
    if (scan_strobe) discrete_command_image = nxt;
  end
endmodule : hzs_host_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hzs_pkg::*;
  localparam int CALC = 20;
  localparam int PSETC = 10;
  int seed = 32'h9cd1_3856;
  int fails = 0;
  int n_checks = 0;
  int k;
  logic [31:0] r;
  logic clk = 1'b0, rst_n = 1'b0, scan_strobe, tune_run, tune_step_method, measure_hold;
  logic [CMD_W-1:0] discrete_command_image, cmd_next = '0;
  logic [STAT_W-1:0] status_flag_image;
  logic [NCH-1:0][15:0] meas_temp = '0, setpoint = '0, upper_alarm = {NCH{16'h0258}}, lower_alarm = {NCH{16'h0190}};
  logic [NCH-1:0][15:0] upper_dev = {NCH{16'h0208}}, lower_dev = {NCH{16'h01e0}};
  logic [NCH-1:0][1:0] thermocouple_code = '0;
  logic [NCH-1:0] channel_active = '0, driver_short = '0, tune_select, closed_loop, output_enable;
  logic [15:0] comp_temp = '0;
  logic cj_sensor_short = 1'b0, cj_sensor_open = 1'b0, ext_supply_ok = 1'b1, cal_request = 1'b0, tune_done = 1'b0;
  logic eprom_fault = 1'b0, ram_fault = 1'b0, int_supply_fault = 1'b0, param_fault = 1'b0;
  logic [7:0] param_fault_id = '0;
  logic [NCH-1:0][NPARAM-1:0][15:0] tuned_params = '0;
  logic [7:0][15:0] feedback_words;
  always #50 clk = ~clk;
  hzs_host_model u_host (.clk, .rst_n, .cmd_next, .scan_strobe, .discrete_command_image);
  hzs_io #(.CAL_CYCLES(CALC), .PSET_CYCLES(PSETC), .HB_CYCLES(4)) dut (.clk, .rst_n, .scan_strobe,
    .discrete_command_image, .status_flag_image, .meas_temp, .upper_alarm, .lower_alarm, .upper_dev, .lower_dev,
    .setpoint, .thermocouple_code, .channel_active, .driver_short, .comp_temp, .cj_sensor_short, .cj_sensor_open,
    .ext_supply_ok, .cal_request, .eprom_fault, .ram_fault, .int_supply_fault, .param_fault, .param_fault_id,
    .tune_done, .tuned_params, .tune_run, .tune_step_method, .tune_select, .closed_loop, .output_enable,
    .measure_hold, .feedback_words);
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_up(bit hit);
    if (hit) begin
      fails++;
      conclude();
    end
  endtask : give_up
  task automatic scans(int n);
    int w;
    repeat (n) begin
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!scan_strobe && w < 40);
      give_up(w >= 40);
    end
    #1;
  endtask : scans
  function automatic logic [63:0] exp_stat();
    logic [63:0] s = '0;
    logic inr;
    logic [3:0] f;
    if (!ext_supply_ok) return 64'h4000_0000_0000_0000;
    inr = !comp_temp[15] && comp_temp <= CJ_MAX;
    for (int i = 0; i < NCH; i++) begin
      f = {$signed(meas_temp[i]) < $signed(lower_dev[i]), $signed(meas_temp[i]) > $signed(upper_dev[i]),
           $signed(meas_temp[i]) < $signed(lower_alarm[i]), $signed(meas_temp[i]) > $signed(upper_alarm[i])};
      if (!inr || thermocouple_code[i][0]) f = 4'h0;
      else if (f[0]) f = 4'h1;
      else if (f[2]) f = 4'h4;
      else if (f[1]) f = 4'h2;
      s[7*i +: 7] = {inr & thermocouple_code[i][1], driver_short[i], inr & thermocouple_code[i][0], f};
    end
    s[ST_REF_FAULT] = cj_sensor_short | cj_sensor_open;
    return s;
  endfunction : exp_stat
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    // Random conditions; the first pass puts every channel exactly on an alarm limit.
    for (int it = 0; it < 30; it++) begin
      for (int i = 0; i < NCH; i++) begin
        r = $random(seed);
        meas_temp[i] = 16'h012c + r[8:0];
        thermocouple_code[i] = r[11] ? TC_OK : r[10:9];
        driver_short[i] = r[12] & r[13];
      end
      if (it == 0) meas_temp = {4{16'h0190, 16'h0258}};
      comp_temp = 16'({16'h0259, 16'hffff, 16'h0000, 16'h0258} >> (16 * r[15:14]));
      ext_supply_ok = r[18:16] != 3'h0;
      {cj_sensor_short, cj_sensor_open} = r[20:19] & r[22:21];
      cmd_next = {8'h00, r[31:16]};
      scans(2);
      check(status_flag_image & ~(64'h1 << ST_HEARTBEAT), exp_stat());
      for (int i = 0; i < NCH; i++) check({output_enable[i], closed_loop[i]}, cmd_next[2*i +: 2]);
    end
    ext_supply_ok = 1'b1;
    k = 0;
    repeat (8) begin
      scans(1);
      k = k | (1 << status_flag_image[ST_HEARTBEAT]);
    end
    check(k, 2'h3);
    {eprom_fault, ram_fault, int_supply_fault, param_fault, param_fault_id} = 12'hf35;
    scans(2);
    check({status_flag_image[ST_MOD_ERR], status_flag_image[ST_HEARTBEAT], feedback_words[7]}, 18'h2_3583);
    {eprom_fault, ram_fault, int_supply_fault, param_fault} = 4'h0;
    for (int d = 1; d >= 0; d--) begin
      cmd_next[CMD_CAL_DIS] = d[0];
      scans(2);
      cal_request = 1'b1;
      @(posedge clk);
      #1 cal_request = 1'b0;
      k = measure_hold;
      r = '0;
      repeat (CALC + 8) begin
        @(posedge clk);
        #1 k += measure_hold;
        r = r | status_flag_image[ST_CAL];
      end
      check(r[0], !d[0]);
      if (d[0]) check(k, 1'b0);
      else check(k >= CALC && k <= CALC + 1, 1'b1);
    end
    // Channels 0 and 1 qualify; 2 has no setpoint, 3 a sensor fault, 4 to 7 run closed loop.
    {channel_active, comp_temp} = 24'hff_0100;
    setpoint = {NCH{16'h00c8}};
    setpoint[2] = 16'h0000;
    thermocouple_code = {8'h00, TC_OPEN, 6'h00};
    for (int m = 1; m >= 0; m--) begin
      cmd_next = 24'h00_ffaa;
      scans(2);
      cmd_next = {4'h0, 1'b1, m[0], 18'h0_ffaa};
      scans(1);
      k = 0;
      while (tune_run !== 1'b1 && k < 20) begin
        @(posedge clk);
        #1 k++;
      end
      give_up(k >= 20);
      check({tune_step_method, tune_select}, {m[0], 8'h03});
      scans(1);
      check(status_flag_image[ST_TUNING], 1'b1);
      if (m == 1) begin
        for (int i = 0; i < NCH * NPARAM; i++) tuned_params[i / NPARAM][i % NPARAM] = 16'($random(seed));
        tune_done = 1'b1;
        @(posedge clk);
        #1 tune_done = 1'b0;
        repeat (PSETC / 2) @(posedge clk);
        for (int c = 0; c < NCH; c++) begin
          #1 check(feedback_words[0][7:0], c < 2 ? c + 1 : 0);
          check(feedback_words[4:1], c < 2 ? tuned_params[c][3:0] : 64'h0);
          check(feedback_words[6:5], c < 2 ? tuned_params[c][5:4] : 32'h0);
          check(feedback_words[0][15:8], 8'hff);
          repeat (PSETC) @(posedge clk);
        end
        scans(2);
        check(status_flag_image[ST_TUNING], 1'b0);
      end else begin
        cmd_next[CMD_TUNE_CANCEL] = 1'b1;
        scans(2);
        check(tune_run, 1'b0);
        cmd_next[CMD_TUNE_CANCEL] = 1'b0;
        scans(3);
        check(tune_run, 1'b0);
      end
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
